// >>> design/bmx_pkg.sv
// constants and carrier types for the bus matrix and its bridges
package bmx_pkg;

  // sizes
  localparam int DATA_W = 32;
  localparam int NUM_MST = 3;
  localparam int NUM_BRIDGE = 3;
  localparam int NUM_ARB_SLV = 4;
  localparam int NUM_SRAM_PORT = 7;
  localparam int NUM_DIRECT = 4;
  localparam int PERIPH_IDX_LSB = 10;
  localparam int PERIPH_IDX_W = 5;
  localparam int NUM_PERIPH = 32;

  // master numbering
  localparam logic [1:0] MST_CORE = 2'h0;
  localparam logic [1:0] MST_DEBUG = 2'h1;
  localparam logic [1:0] MST_DMA = 2'h2;

  // slave numbering; sram slaves 4..6 are picked by the master
  localparam logic [2:0] SLV_FLASH = 3'h0;
  localparam logic [2:0] SLV_BRIDGE_A = 3'h1;
  localparam logic [2:0] SLV_BRIDGE_B = 3'h2;
  localparam logic [2:0] SLV_BRIDGE_C = 3'h3;
  localparam logic [2:0] SLV_SRAM_CORE = 3'h4;
  localparam logic [2:0] SLV_SRAM_DMA = 3'h5;
  localparam logic [2:0] SLV_SRAM_DEBUG = 3'h6;

  // sram port numbering
  localparam logic [2:0] SRAM_PORT_TRACE = 3'h0;
  localparam logic [2:0] SRAM_PORT_USB = 3'h1;
  localparam logic [2:0] SRAM_PORT_DMA_WB = 3'h2;
  localparam logic [2:0] SRAM_PORT_DMA_FETCH = 3'h3;
  localparam logic [2:0] SRAM_PORT_CORE = 3'h4;
  localparam logic [2:0] SRAM_PORT_DMA_DATA = 3'h5;
  localparam logic [2:0] SRAM_PORT_DEBUG = 3'h6;

  // service levels
  localparam logic [1:0] QOS_BACKGROUND = 2'h0;
  localparam logic [1:0] QOS_BANDWIDTH = 2'h1;
  localparam logic [1:0] QOS_LATENCY = 2'h2;
  localparam logic [1:0] QOS_CRITICAL = 2'h3;
  localparam logic [1:0] QOS_TRACE = 2'h3;
  localparam logic [1:0] QOS_DEBUG = 2'h1;
  localparam logic [1:0] CORE_QOS_RESET = 2'h0;

  // address map, decoded on addr[31:24]
  localparam logic [7:0] REGION_FLASH = 8'h00;
  localparam logic [7:0] REGION_SRAM = 8'h20;
  localparam logic [7:0] REGION_BRIDGE_A = 8'h40;
  localparam logic [7:0] REGION_BRIDGE_B = 8'h41;
  localparam logic [7:0] REGION_BRIDGE_C = 8'h42;
  localparam logic [31:0] CORE_QOS_ADDR = 32'h4100_7110;
  localparam int BRIDGE_QOS_IDX = 1;
  localparam logic [9:0] GUARD_CLR_OFS = 10'h000;
  localparam logic [9:0] GUARD_SET_OFS = 10'h004;

  // transfer sizes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic write;
    logic [1:0] size;
    logic [DATA_W-1:0] wdata;
    logic [3:0] prot;
  } bmx_req_type;

  typedef struct packed {
    logic done;
    logic err;
    logic [DATA_W-1:0] rdata;
  } bmx_rsp_type;

  typedef struct packed {
    logic sel;
    logic enable;
    logic [31:0] addr;
    logic write;
    logic [DATA_W-1:0] wdata;
    logic [3:0] strb;
    logic [3:0] prot;
  } bmx_apb_type;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic write;
    logic [DATA_W-1:0] wdata;
    logic [1:0] size;
  } bmx_sram_port_type;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic write;
    logic [DATA_W-1:0] wdata;
    logic [3:0] be;
  } bmx_sram_cmd_type;

  typedef enum logic [1:0] {
    BR_IDLE,
    BR_CHECK,
    BR_APB
  } bmx_br_state_type;

endpackage : bmx_pkg

// >>> design/bmx_write_guard.sv
// per-bridge peripheral write-protect bits with set and clear ports
`timescale 1ns/10ps
`default_nettype none

module bmx_write_guard #(
  parameter int NUM_PERIPH = 32,
  parameter logic [NUM_PERIPH-1:0] PROT_RESET = '0
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // register writes
  input wire logic clk_en,
  input wire logic wr_clear,
  input wire logic wr_set,
  input wire logic [NUM_PERIPH-1:0] wdata,
  // protection state
  output logic [NUM_PERIPH-1:0] prot,
  output logic double_err
);

  logic [NUM_PERIPH-1:0] clr_mask;
  logic [NUM_PERIPH-1:0] set_mask;
  logic [NUM_PERIPH-1:0] next_prot;

  // zero bits in the written word select nothing
  assign clr_mask = (wr_clear && clk_en) ? wdata : '0; // R18 R23
  assign set_mask = (wr_set && clk_en) ? wdata : '0; // R19 R23
  assign double_err = (|(set_mask & prot)) || (|(clr_mask & ~prot)); // R22
  // one vector backs both register views
  assign next_prot = (prot | set_mask) & ~clr_mask; // R18 R19 R20

  // runs on ref_clk and takes writes only while clk_en is high, so it keeps going in any sleep that leaves clk_en set
  always_ff @(posedge ref_clk) begin // R16
    if (!rst_n) begin
      prot <= PROT_RESET;
    end else begin
      prot <= next_prot;
    end
  end

endmodule : bmx_write_guard

`default_nettype wire

// >>> design/bmx_matrix.sv
// bus matrix with sram service-level arbiter and guarded apb bridges
`timescale 1ns/10ps
`default_nettype none

// Contract
// R1 - masters reach different slaves concurrently
// R2 - 32-bit data, same clock as masters
// R3 - masters: core 0, debug 1, dma 2
// R4 - slaves: flash, three bridges, three sram
// R5 - seven sram ports, four direct, three matrix
// R6 - every sram access carries a 2-bit level
// R7 - levels 0 and 1 wait one cycle
// R8 - highest level wins, then lowest port
// R9 - trace level 3, debug level 1, fixed
// R10 - core level register bits 1:0, reset zero
// R11 - bridge forwards to apb with waits, errors
// R12 - apb address and data in one cycle
// R13 - byte lanes apply to reads too
// R14 - bridge runs only with its clock enabled; code gates new grants only, a started transfer finishes
// R15 - one guard per bridge, bit per peripheral
// R16 - guard keeps working while its clock runs
// R17 - debugger writes bypass protection
// R18 - clear register one bit unprotects
// R19 - set register one bit protects
// R20 - both registers read the same vector
// R21 - protected write dropped with error response
// R22 - double protect or unprotect returns error
// R23 - zero bits leave protection unchanged
module bmx_matrix #(
  parameter logic [31:0] GUARD_PROT_RESET = 32'h0000_0000
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // masters: core, debug, dma data
  input wire bmx_pkg::bmx_req_type mst_req [bmx_pkg::NUM_MST],
  output var bmx_pkg::bmx_rsp_type mst_rsp [bmx_pkg::NUM_MST],
  // flash slave
  output var bmx_pkg::bmx_req_type flash_req,
  input wire bmx_pkg::bmx_rsp_type flash_rsp,
  // peripheral bridges
  input wire logic [bmx_pkg::NUM_BRIDGE-1:0] bridge_clk_en,
  input wire logic [bmx_pkg::NUM_BRIDGE-1:0] guard_clk_en,
  output var bmx_pkg::bmx_apb_type apb_out [bmx_pkg::NUM_BRIDGE],
  input wire logic [bmx_pkg::NUM_BRIDGE-1:0] apb_ready,
  input wire logic [bmx_pkg::NUM_BRIDGE-1:0] apb_slverr,
  input wire logic [bmx_pkg::DATA_W-1:0] apb_rdata [bmx_pkg::NUM_BRIDGE],
  // direct sram ports, their levels and the dma data port level
  input wire bmx_pkg::bmx_sram_port_type direct_port [bmx_pkg::NUM_DIRECT],
  input wire logic [1:0] usb_qos,
  input wire logic [1:0] dma_wb_qos,
  input wire logic [1:0] dma_fetch_qos,
  input wire logic [1:0] dma_data_qos,
  output logic [bmx_pkg::NUM_DIRECT-1:0] direct_done,
  output logic [bmx_pkg::DATA_W-1:0] direct_rdata,
  // sram array
  output var bmx_pkg::bmx_sram_cmd_type sram_cmd,
  output logic [1:0] sram_cmd_qos,
  input wire logic [bmx_pkg::DATA_W-1:0] sram_rdata
);

  localparam int NM = bmx_pkg::NUM_MST;
  localparam int NB = bmx_pkg::NUM_BRIDGE;
  localparam int NS = bmx_pkg::NUM_ARB_SLV;
  localparam int NP = bmx_pkg::NUM_SRAM_PORT;
  localparam int ND = bmx_pkg::NUM_DIRECT;
  localparam int DW = bmx_pkg::DATA_W; // R2
  localparam int PW = bmx_pkg::PERIPH_IDX_W;
  localparam int LSB = bmx_pkg::PERIPH_IDX_LSB;

  function automatic logic [3:0] lane_strb(input logic [1:0] size, input logic [1:0] ofs);
    logic [3:0] res;
    res = 4'hF;
    if (size == bmx_pkg::SIZE_BYTE) begin
      res = 4'h1 << ofs;
    end else if (size == bmx_pkg::SIZE_HALF) begin
      res = ofs[1] ? 4'hC : 4'h3;
    end
    return res;
  endfunction : lane_strb

  // {hit, slave}; any sram address reports the core sram slave
  function automatic logic [3:0] decode_slave(input logic [31:0] addr);
    logic [3:0] res;
    res = 4'h0;
    if (addr[31:24] == bmx_pkg::REGION_FLASH) begin
      res = {1'b1, bmx_pkg::SLV_FLASH};
    end else if (addr[31:24] == bmx_pkg::REGION_SRAM) begin
      res = {1'b1, bmx_pkg::SLV_SRAM_CORE};
    end else if (addr[31:24] == bmx_pkg::REGION_BRIDGE_A) begin
      res = {1'b1, bmx_pkg::SLV_BRIDGE_A};
    end else if (addr[31:24] == bmx_pkg::REGION_BRIDGE_B) begin
      res = {1'b1, bmx_pkg::SLV_BRIDGE_B};
    end else if (addr[31:24] == bmx_pkg::REGION_BRIDGE_C) begin
      res = {1'b1, bmx_pkg::SLV_BRIDGE_C};
    end
    return res;
  endfunction : decode_slave

  function automatic logic [1:0] onehot_index(input logic [NM-1:0] vec);
    logic [1:0] idx;
    idx = 2'h0;
    for (int i = 0; i < NM; i++) begin
      if (vec[i]) begin
        idx = 2'(i);
      end
    end
    return idx;
  endfunction : onehot_index

  // each matrix master owns one sram port
  function automatic logic [2:0] mst_port(input logic [1:0] mst);
    logic [2:0] port;
    case (mst)
      bmx_pkg::MST_CORE: port = bmx_pkg::SRAM_PORT_CORE;
      bmx_pkg::MST_DEBUG: port = bmx_pkg::SRAM_PORT_DEBUG;
      default: port = bmx_pkg::SRAM_PORT_DMA_DATA;
    endcase
    return port;
  endfunction : mst_port

  logic [3:0] mst_dec [NM];
  logic [NM-1:0] take;
  logic [NM-1:0] to_sram;
  logic [NM-1:0] to_none;
  logic [NM-1:0] slv_gnt [NS];
  logic [NS-1:0] slv_busy;
  logic [NS-1:0] slv_open;
  logic [1:0] flash_owner;
  logic flash_fin;
  logic [NB-1:0] br_fin;
  logic [NB-1:0] br_err;
  logic [NB-1:0] br_qos_wr;
  logic [DW-1:0] br_rdata [NB];
  logic [1:0] br_owner [NB];
  logic [1:0] core_qos;
  logic [DW-1:0] qos_wdata;
  logic [1:0] port_qos [NP];
  bmx_pkg::bmx_sram_port_type pv [NP];
  logic [NP-1:0] preq;
  logic [NP-1:0] elig;
  logic [NP-1:0] aged;
  logic [NP-1:0] sram_out;
  logic [NP-1:0] sram_gnt;
  logic [NP-1:0] ret_done;
  logic sel_found;
  logic [2:0] sel_port;
  logic [1:0] sel_qos;
  logic [2:0] cmd_port;
  logic ret_valid;
  logic [2:0] ret_port;
  bmx_pkg::bmx_sram_cmd_type next_cmd;

  genvar gm, gs, gb, gp;

  // per master: decode, take, answer
  for (gm = 0; gm < NM; gm++) begin : g_mst
    logic busy;
    logic granted;
    bmx_pkg::bmx_rsp_type next_rsp;
    assign mst_dec[gm] = decode_slave(mst_req[gm].addr);
    // done still high blocks a second take of the request being answered
    assign take[gm] = mst_req[gm].valid && !busy && !mst_rsp[gm].done;
    assign to_none[gm] = take[gm] && !mst_dec[gm][3];
    assign to_sram[gm] = take[gm] && (mst_dec[gm] == {1'b1, bmx_pkg::SLV_SRAM_CORE});
    always_comb begin
      granted = to_sram[gm] || to_none[gm];
      for (int s = 0; s < NS; s++) begin
        granted = granted || slv_gnt[s][gm];
      end
      next_rsp = '0;
      if (to_none[gm]) begin
        next_rsp.done = 1'b1;
        next_rsp.err = 1'b1;
      end
      if (flash_fin && flash_owner == 2'(gm)) begin
        next_rsp.done = 1'b1;
        next_rsp.err = flash_rsp.err;
        next_rsp.rdata = flash_rsp.rdata;
      end
      for (int b = 0; b < NB; b++) begin
        if (br_fin[b] && br_owner[b] == 2'(gm)) begin
          next_rsp.done = 1'b1;
          next_rsp.err = br_err[b];
          next_rsp.rdata = br_rdata[b];
        end
      end
      if (ret_valid && ret_port == mst_port(2'(gm))) begin
        next_rsp.done = 1'b1;
        next_rsp.rdata = sram_rdata;
      end
    end
    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        busy <= 1'b0;
        mst_rsp[gm] <= '0;
      end else begin
        busy <= next_rsp.done ? 1'b0 : (granted || busy);
        mst_rsp[gm] <= next_rsp;
      end
    end
  end

  // per shared slave: lowest free master wins; distinct slaves never interact
  assign slv_busy[0] = flash_req.valid;
  assign slv_open[0] = 1'b1;
  assign slv_open[NS-1:1] = bridge_clk_en; // R14
  for (gs = 0; gs < NS; gs++) begin : g_slv
    logic [NM-1:0] gnt;
    always_comb begin // R1
      gnt = '0;
      for (int m = 0; m < NM; m++) begin
        if (take[m] && mst_dec[m] == {1'b1, 3'(gs)} && !slv_busy[gs] && slv_open[gs] && gnt == '0) begin
          gnt[m] = 1'b1;
        end
      end
    end
    assign slv_gnt[gs] = gnt;
  end

  assign flash_fin = flash_req.valid && flash_rsp.done;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      flash_req <= '0;
      flash_owner <= 2'h0;
    end else if (|slv_gnt[0]) begin
      flash_req <= mst_req[onehot_index(slv_gnt[0])];
      flash_owner <= onehot_index(slv_gnt[0]);
    end else if (flash_fin) begin
      flash_req.valid <= 1'b0;
    end
  end

  // bridges, each with its own guard
  for (gb = 0; gb < NB; gb++) begin : g_br
    bmx_pkg::bmx_br_state_type state;
    bmx_pkg::bmx_req_type cap;
    bmx_pkg::bmx_apb_type apb_load;
    logic [1:0] own;
    logic [DW-1:0] prot;
    logic [DW-1:0] local_rdata;
    logic [PW-1:0] pidx;
    logic [3:0] strb;
    logic dbl_err;
    logic guard_win;
    logic clr_hit;
    logic set_hit;
    logic qos_hit;
    logic local_hit;
    logic blocked;
    logic in_check;
    logic wr_clr;
    logic wr_set;
    logic local_err;

    assign pidx = cap.addr[LSB +: PW];
    assign strb = lane_strb(cap.size, cap.addr[1:0]);
    assign guard_win = (pidx == '0); // R15
    assign clr_hit = guard_win && cap.addr[LSB-1:0] == bmx_pkg::GUARD_CLR_OFS;
    assign set_hit = guard_win && cap.addr[LSB-1:0] == bmx_pkg::GUARD_SET_OFS;
    assign qos_hit = (gb == bmx_pkg::BRIDGE_QOS_IDX) && cap.addr == bmx_pkg::CORE_QOS_ADDR;
    assign local_hit = guard_win || qos_hit;
    assign blocked = cap.write && own != bmx_pkg::MST_DEBUG && prot[pidx] && !local_hit; // R17 R21
    assign in_check = (state == bmx_pkg::BR_CHECK);
    assign wr_clr = in_check && cap.write && clr_hit;
    assign wr_set = in_check && cap.write && set_hit;
    assign local_err = (guard_win && !clr_hit && !set_hit) || ((wr_clr || wr_set) && dbl_err); // R22
    assign local_rdata = (clr_hit || set_hit) ? prot : (qos_hit ? {{(DW-2){1'b0}}, core_qos} : '0); // R20
    // single merged cycle: select and enable rise together, lanes for reads too
    assign apb_load = '{sel: 1'b1, enable: 1'b1, addr: cap.addr, write: cap.write,
                        wdata: cap.wdata, strb: strb, prot: cap.prot}; // R11 R12 R13

    assign br_fin[gb] = (in_check && (local_hit || blocked)) || (state == bmx_pkg::BR_APB && apb_ready[gb]);
    assign br_err[gb] = in_check ? (local_err || blocked) : apb_slverr[gb]; // R11 R21
    assign br_rdata[gb] = in_check ? local_rdata : apb_rdata[gb];
    assign br_owner[gb] = own;
    assign br_qos_wr[gb] = in_check && qos_hit && cap.write && strb[0]; // R10
    assign slv_busy[gb+1] = (state != bmx_pkg::BR_IDLE);

    bmx_write_guard #(
      .NUM_PERIPH(bmx_pkg::NUM_PERIPH),
      .PROT_RESET(GUARD_PROT_RESET)
    ) u_guard (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .clk_en(guard_clk_en[gb]),
      .wr_clear(wr_clr),
      .wr_set(wr_set),
      .wdata(cap.wdata),
      .prot(prot),
      .double_err(dbl_err)
    );

    always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
        state <= bmx_pkg::BR_IDLE;
        cap <= '0;
        own <= 2'h0;
        apb_out[gb] <= '0;
      end else begin
        case (state)
          bmx_pkg::BR_IDLE: begin
            if (|slv_gnt[gb+1]) begin
              state <= bmx_pkg::BR_CHECK;
              cap <= mst_req[onehot_index(slv_gnt[gb+1])];
              own <= onehot_index(slv_gnt[gb+1]);
            end
          end
          bmx_pkg::BR_CHECK: begin
            // a blocked write never reaches the peripheral
            if (local_hit || blocked) begin // R21
              state <= bmx_pkg::BR_IDLE;
            end else begin
              state <= bmx_pkg::BR_APB;
              apb_out[gb] <= apb_load;
            end
          end
          bmx_pkg::BR_APB: begin
            // wait states: hold until the peripheral is ready
            if (apb_ready[gb]) begin // R11
              state <= bmx_pkg::BR_IDLE;
              apb_out[gb].sel <= 1'b0;
              apb_out[gb].enable <= 1'b0;
            end
          end
          default: begin
            state <= bmx_pkg::BR_IDLE;
          end
        endcase
      end
    end
  end

  assign qos_wdata = g_br[bmx_pkg::BRIDGE_QOS_IDX].cap.wdata;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      core_qos <= bmx_pkg::CORE_QOS_RESET; // R10
    end else if (|br_qos_wr) begin
      core_qos <= qos_wdata[1:0]; // R10
    end
  end

  // sram service levels per port
  assign port_qos[bmx_pkg::SRAM_PORT_TRACE] = bmx_pkg::QOS_TRACE; // R9
  assign port_qos[bmx_pkg::SRAM_PORT_USB] = usb_qos; // R6
  assign port_qos[bmx_pkg::SRAM_PORT_DMA_WB] = dma_wb_qos;
  assign port_qos[bmx_pkg::SRAM_PORT_DMA_FETCH] = dma_fetch_qos;
  assign port_qos[bmx_pkg::SRAM_PORT_CORE] = core_qos; // R10
  assign port_qos[bmx_pkg::SRAM_PORT_DMA_DATA] = dma_data_qos;
  assign port_qos[bmx_pkg::SRAM_PORT_DEBUG] = bmx_pkg::QOS_DEBUG; // R9

  for (gp = 0; gp < NP; gp++) begin : g_port
    if (gp < ND) begin : g_direct
      // direct ports bypass the matrix
      assign pv[gp] = direct_port[gp]; // R5
      assign preq[gp] = direct_port[gp].valid && !direct_done[gp];
    end else begin : g_matrix
      logic pend;
      logic [1:0] src;
      bmx_pkg::bmx_sram_port_type hold;
      assign src = (gp == bmx_pkg::SRAM_PORT_CORE) ? bmx_pkg::MST_CORE :
                   ((gp == bmx_pkg::SRAM_PORT_DEBUG) ? bmx_pkg::MST_DEBUG : bmx_pkg::MST_DMA); // R3 R4
      assign pv[gp] = hold; // R5
      assign preq[gp] = pend;
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          pend <= 1'b0;
          hold <= '0;
        end else if (to_sram[src]) begin
          pend <= 1'b1;
          hold <= '{valid: 1'b1, addr: mst_req[src].addr, write: mst_req[src].write,
                    wdata: mst_req[src].wdata, size: mst_req[src].size};
        end else if (sram_gnt[gp]) begin
          pend <= 1'b0;
        end
      end
    end
    // low levels must first sit out one cycle
    assign elig[gp] = preq[gp] && !sram_out[gp] && (port_qos[gp][1] || aged[gp]); // R7
  end

  // scan from the top port down so ties fall to the lowest port
  always_comb begin // R8
    sel_found = 1'b0;
    sel_port = 3'h0;
    sel_qos = 2'h0;
    for (int p = NP - 1; p >= 0; p--) begin
      if (elig[p] && (!sel_found || port_qos[p] >= sel_qos)) begin
        sel_found = 1'b1;
        sel_port = 3'(p);
        sel_qos = port_qos[p];
      end
    end
  end

  assign sram_gnt = sel_found ? ({{(NP-1){1'b0}}, 1'b1} << sel_port) : '0;
  assign ret_done = ret_valid ? ({{(NP-1){1'b0}}, 1'b1} << ret_port) : '0;
  assign next_cmd = '{valid: sel_found, addr: pv[sel_port].addr, write: pv[sel_port].write,
                      wdata: pv[sel_port].wdata,
                      be: lane_strb(pv[sel_port].size, pv[sel_port].addr[1:0])};

  // one access per cycle; data returns the cycle after the command
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      sram_cmd <= '0;
      sram_cmd_qos <= 2'h0;
      cmd_port <= 3'h0;
      ret_valid <= 1'b0;
      ret_port <= 3'h0;
      sram_out <= '0;
      aged <= '0;
      direct_done <= '0;
      direct_rdata <= '0;
    end else begin
      sram_cmd <= next_cmd;
      sram_cmd_qos <= sel_qos; // R6
      cmd_port <= sel_port;
      ret_valid <= sram_cmd.valid;
      ret_port <= cmd_port;
      sram_out <= (sram_out | sram_gnt) & ~ret_done;
      aged <= preq & ~sram_out & ~sram_gnt; // R7
      direct_done <= ret_done[ND-1:0];
      if (ret_valid) begin
        direct_rdata <= sram_rdata;
      end
    end
  end

endmodule : bmx_matrix

`default_nettype wire

// >>> verif/bmx_far_model.sv
// apb peripherals, flash and sram array answering the matrix
`timescale 1ns/10ps
`default_nettype none
module bmx_far_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // pace of the peripherals
  input wire logic slow,
  // apb side
  input wire bmx_pkg::bmx_apb_type apb_out [bmx_pkg::NUM_BRIDGE],
  output logic [bmx_pkg::NUM_BRIDGE-1:0] apb_ready,
  output logic [bmx_pkg::NUM_BRIDGE-1:0] apb_slverr,
  output logic [31:0] apb_rdata [bmx_pkg::NUM_BRIDGE],
  // flash and sram
  input wire bmx_pkg::bmx_req_type flash_req,
  output bmx_pkg::bmx_rsp_type flash_rsp,
  input wire bmx_pkg::bmx_sram_cmd_type sram_cmd,
  output logic [31:0] sram_rdata
);
  logic [31:0] mem [64];
  logic [1:0] tick;
  always_ff @(posedge ref_clk) begin
    tick <= rst_n ? tick + 2'h1 : 2'h0;
    for (int b = 0; b < 3; b++) begin
      apb_ready[b] <= rst_n && apb_out[b].sel && !apb_ready[b] && (!slow || tick == 2'h3);
      apb_slverr[b] <= 1'b0;
      apb_rdata[b] <= apb_out[b].sel ? ~apb_out[b].addr : $random;
    end
    flash_rsp <= '{rst_n && flash_req.valid && !flash_rsp.done, 1'b0, ~flash_req.addr};
    if (sram_cmd.valid && sram_cmd.write) begin
      mem[sram_cmd.addr[7:2]] <= sram_cmd.wdata;
    end
    sram_rdata <= sram_cmd.valid ? mem[sram_cmd.addr[7:2]] : ~sram_rdata;
  end
endmodule : bmx_far_model
`default_nettype wire

// >>> verif/bmx_matrix_assertions.sv
// concurrent checks on the bus matrix ports
`timescale 1ns/10ps
`default_nettype none
module bmx_matrix_assertions (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // watched ports
  input wire bmx_pkg::bmx_req_type mst_req [bmx_pkg::NUM_MST],
  input wire bmx_pkg::bmx_rsp_type mst_rsp [bmx_pkg::NUM_MST],
  input wire bmx_pkg::bmx_req_type flash_req,
  input wire bmx_pkg::bmx_rsp_type flash_rsp,
  input wire logic [bmx_pkg::NUM_BRIDGE-1:0] bridge_clk_en,
  input wire bmx_pkg::bmx_apb_type apb_out [bmx_pkg::NUM_BRIDGE],
  input wire logic [bmx_pkg::NUM_BRIDGE-1:0] apb_ready,
  input wire logic [bmx_pkg::NUM_DIRECT-1:0] direct_done,
  input wire bmx_pkg::bmx_sram_cmd_type sram_cmd
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  apb_merged_a: assert property (apb_out[0].sel |-> apb_out[0].enable)
    else $error("apb select without enable");
  apb_hold_a: assert property (apb_out[0].sel && !apb_ready[0] |=>
    apb_out[0].sel && $stable(apb_out[0].addr)) else $error("apb dropped before ready");
  apb_gated_a: assert property (!bridge_clk_en[2] ##1 !bridge_clk_en[2] &&
    !apb_out[2].sel |=> !apb_out[2].sel) else $error("bridge started with clock off");
  lane_select_a: assert property (apb_out[0].sel |-> apb_out[0].strb != 4'h0)
    else $error("apb access without byte lanes");
  done_pulse_a: assert property (mst_rsp[0].done |=> !mst_rsp[0].done)
    else $error("done longer than one cycle");
  sram_answer_a: assert property (sram_cmd.valid |-> ##2 (direct_done != 4'h0 ||
    mst_rsp[0].done || mst_rsp[1].done || mst_rsp[2].done)) else $error("sram answer late");
  flash_hold_a: assert property (flash_req.valid && !flash_rsp.done |=> flash_req.valid)
    else $error("flash request dropped");
  debug_slow_a: assert property ($rose(mst_req[1].valid) &&
    mst_req[1].addr[31:24] == 8'h20 |=> (!mst_rsp[1].done) [*4])
    else $error("low level sram access too fast");
endmodule : bmx_matrix_assertions
bind bmx_matrix bmx_matrix_assertions chk (.ref_clk, .rst_n, .mst_req, .mst_rsp, .flash_req,
  .flash_rsp, .bridge_clk_en, .apb_out, .apb_ready, .direct_done, .sram_cmd);
`default_nettype wire

// >>> verif/bmx_matrix_test.sv
// self-checking bench for the bus matrix
`timescale 1ns/10ps
`default_nettype none
module bmx_matrix_test;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic slow = 1'b0;
  bmx_pkg::bmx_req_type mst_req [bmx_pkg::NUM_MST];
  bmx_pkg::bmx_rsp_type mst_rsp [bmx_pkg::NUM_MST];
  bmx_pkg::bmx_req_type flash_req;
  bmx_pkg::bmx_rsp_type flash_rsp;
  logic [2:0] bridge_clk_en = 3'h7;
  logic [2:0] guard_clk_en = 3'h7;
  bmx_pkg::bmx_apb_type apb_out [bmx_pkg::NUM_BRIDGE];
  logic [2:0] apb_ready;
  logic [2:0] apb_slverr;
  logic [31:0] apb_rdata [bmx_pkg::NUM_BRIDGE];
  bmx_pkg::bmx_sram_port_type direct_port [bmx_pkg::NUM_DIRECT];
  logic [1:0] usb_qos = 2'h3;
  logic [1:0] qos_tie = 2'h2;
  logic [3:0] direct_done;
  logic [31:0] direct_rdata;
  bmx_pkg::bmx_sram_cmd_type sram_cmd;
  logic [1:0] sram_cmd_qos;
  logic [31:0] sram_rdata;
  integer seed = 32'hf471b073;
  integer failures = 0;
  integer checks = 0;
  integer cycles = 0;
  integer apb_cnt [3] = '{0, 0, 0};
  logic [31:0] mask;
  logic [31:0] d;
  bmx_pkg::bmx_rsp_type rsp;
  bmx_pkg::bmx_rsp_type rsp2;
  bmx_matrix DUT (.ref_clk, .rst_n, .mst_req, .mst_rsp, .flash_req, .flash_rsp, .bridge_clk_en,
    .guard_clk_en, .apb_out, .apb_ready, .apb_slverr, .apb_rdata, .direct_port, .usb_qos,
    .dma_wb_qos(qos_tie), .dma_fetch_qos(qos_tie), .dma_data_qos(qos_tie), .direct_done,
    .direct_rdata, .sram_cmd, .sram_cmd_qos, .sram_rdata);
  bmx_far_model u_far (.ref_clk, .rst_n, .slow, .apb_out, .apb_ready, .apb_slverr, .apb_rdata,
    .flash_req, .flash_rsp, .sram_cmd, .sram_rdata);
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    for (int b = 0; b < 3; b++) if (apb_out[b].sel && apb_ready[b]) apb_cnt[b]++;
    if (sram_cmd.valid && mst_req[1].valid) check(sram_cmd_qos, bmx_pkg::QOS_DEBUG);
    if (cycles == 5000) begin
      failures++;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic access(input int m, input logic [31:0] a, input logic w, input logic [31:0] wd,
      output bmx_pkg::bmx_rsp_type r);
    int n = 0;
    @(posedge ref_clk) #1;
    mst_req[m] = '{1'b1, a, w, bmx_pkg::SIZE_WORD, wd, 4'h0};
    do begin
      @(posedge ref_clk) #1;
      n++;
    end while (mst_rsp[m].done !== 1'b1 && n < 100);
    if (n >= 100) failures++;
    r = mst_rsp[m];
    // hold past the done edge so the request is not taken twice
    @(posedge ref_clk) #1;
    mst_req[m].valid = 1'b0;
  endtask : access
  task automatic complete_run;
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  initial begin
    int n;
    for (int i = 0; i < 3; i++) mst_req[i] = '0;
    for (int i = 0; i < 4; i++) direct_port[i] = '0;
    repeat (4) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    access(0, bmx_pkg::CORE_QOS_ADDR, 1'b0, 32'h0, rsp);
    check(rsp.rdata, 32'h0);
    mask = $random(seed);
    access(0, bmx_pkg::CORE_QOS_ADDR, 1'b1, mask, rsp);
    access(0, bmx_pkg::CORE_QOS_ADDR, 1'b0, 32'h0, rsp);
    check(rsp.rdata, {30'h0, mask[1:0]});
    mask = ($random(seed) & 32'hffff_fffe) | 32'h0000_0020;
    access(0, 32'h4000_0004, 1'b1, mask, rsp);
    check(rsp.err, 1'b0);
    access(0, 32'h4000_0000, 1'b0, 32'h0, rsp);
    check(rsp.rdata, mask);
    access(0, 32'h4000_0004, 1'b1, mask, rsp);
    check(rsp.err, 1'b1);
    access(0, 32'h4000_0004, 1'b1, 32'h0, rsp);
    access(0, 32'h4000_0004, 1'b0, 32'h0, rsp);
    check(rsp.rdata, mask);
    access(0, 32'h4000_1400, 1'b1, mask, rsp);
    check(rsp.err, 1'b1);
    check(apb_cnt[0], 0);
    access(1, 32'h4000_1400, 1'b1, mask, rsp);
    check(rsp.err, 1'b0);
    check(apb_cnt[0], 1);
    access(0, 32'h4000_0000, 1'b1, mask, rsp);
    access(0, 32'h4000_0004, 1'b0, 32'h0, rsp);
    check(rsp.rdata, 32'h0);
    access(0, 32'h4000_0000, 1'b1, mask, rsp);
    check(rsp.err, 1'b1);
    slow = 1'b1;
    access(0, 32'h4000_1400, 1'b0, 32'h0, rsp);
    check(rsp.rdata, ~32'h4000_1400);
    access(0, 32'h3000_0000, 1'b0, 32'h0, rsp);
    check(rsp.err, 1'b1);
    d = $random(seed);
    access(0, 32'h2000_0010, 1'b1, d, rsp);
    access(1, 32'h2000_0010, 1'b0, 32'h0, rsp);
    check(rsp.rdata, d);
    fork
      access(0, 32'h0000_0100, 1'b0, 32'h0, rsp);
      access(2, 32'h2000_0010, 1'b0, 32'h0, rsp2);
    join
    check(rsp.rdata, ~32'h0000_0100);
    check(rsp2.rdata, d);
    @(posedge ref_clk) #1;
    direct_port[0] = '{1'b1, 32'h2000_0010, 1'b0, 32'h0, bmx_pkg::SIZE_WORD};
    direct_port[1] = direct_port[0];
    for (n = 0; n < 50 && direct_done[1:0] == 2'h0; n++) @(posedge ref_clk) #1;
    direct_port[0].valid = 1'b0;
    check(direct_done[1:0], 2'h1);
    check(direct_rdata, d);
    for (n = 0; n < 50 && direct_done[1] !== 1'b1; n++) @(posedge ref_clk) #1;
    direct_port[1].valid = 1'b0;
    check(direct_rdata, d);
    bridge_clk_en[2] = 1'b0;
    fork
      access(0, 32'h4200_0400, 1'b0, 32'h0, rsp);
      begin
        repeat (8) @(posedge ref_clk);
        #1;
        check(apb_cnt[2], 0);
        bridge_clk_en[2] = 1'b1;
      end
    join
    check(rsp.rdata, ~32'h4200_0400);
    complete_run();
  end
endmodule : bmx_matrix_test
`default_nettype wire
